// ==== hw/hip_pkg.sv ====
// Purpose: shared constants, types and lane helpers of the host index port
// Assumes: 32-bit internal words, 8- or 16-bit host data
// Notes: host offsets are byte addresses of the indexed map
package hip_pkg;
  // host map byte offsets
  localparam logic [4:0] OFS_IDX0 = 5'h00;
  localparam logic [4:0] OFS_DATA0 = 5'h04;
  localparam logic [4:0] OFS_IDX1 = 5'h08;
  localparam logic [4:0] OFS_DATA1 = 5'h0c;
  localparam logic [4:0] OFS_IDX2 = 5'h10;
  localparam logic [4:0] OFS_DATA2 = 5'h14;
  localparam logic [4:0] OFS_FIFO = 5'h18;
  localparam logic [4:0] OFS_CFG = 5'h1c;
  // reset values
  localparam logic [15:0] IDX_RESET = 16'h1234;
  localparam logic [3:0] CFG_RESET = 4'h0;
  // byte-order field: bit per pair, fifo bit above them
  localparam int CFG_FIFO_BIT = 3;
  localparam int CFG_SHADOW_STEP = 8;

  // access target inside the map
  typedef enum logic [1:0] {
    TGT_IDX = 2'h0,
    TGT_DATA = 2'h1,
    TGT_FIFO = 2'h2,
    TGT_CFG = 2'h3
  } hip_tgt_t;

  // cycle state, gray along idle-read and idle-write
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } hip_state_t;

  // which register class an address hits
  function automatic hip_tgt_t tgt_of(input logic [4:0] a);
    case (a[4:2])
      OFS_IDX0[4:2], OFS_IDX1[4:2], OFS_IDX2[4:2]: tgt_of = TGT_IDX;
      OFS_DATA0[4:2], OFS_DATA1[4:2], OFS_DATA2[4:2]: tgt_of = TGT_DATA;
      OFS_FIFO[4:2]: tgt_of = TGT_FIFO;
      default: tgt_of = TGT_CFG;
    endcase
  endfunction

  // byte lanes touched by one host access
  function automatic logic [3:0] lane_be(input logic b16, input logic [1:0] a);
    if (b16) begin
      lane_be = a[1] ? 4'hc : 4'h3;
    end else begin
      lane_be = 4'h1 << a;
    end
  endfunction

  // host-side slice of a dword, low-aligned
  function automatic logic [15:0] lane_pick(input logic [31:0] d, input logic b16,
                                            input logic [1:0] a);
    if (b16) begin
      lane_pick = a[1] ? d[31:16] : d[15:0];
    end else begin
      lane_pick = {8'h00, d[8*a +: 8]};
    end
  endfunction

  // host data copied into every lane it may land in
  function automatic logic [31:0] lane_fill(input logic [15:0] d, input logic b16);
    lane_fill = b16 ? {2{d}} : {4{d[7:0]}};
  endfunction
endpackage

// ==== hw/hip_sync.sv ====
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to mclk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module hip_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, low
  input wire logic [W-1:0] din, // raw pin levels
  output logic [W-1:0] dout // filtered levels
);
  logic [W-1:0] s1_q; // first stage, read only by s2
  logic [W-1:0] s2_q; // second stage
  logic [W-1:0] s3_q; // third stage
  logic [W-1:0] lvl_q; // accepted level
  logic [W-1:0] agree; // stages two and three match

  assign agree = ~(s2_q ^ s3_q);
  assign dout = lvl_q;

  // shift chain; a bit is taken once it has held for two samples
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (agree & s3_q) | (~agree & lvl_q);
    end
  end
endmodule
`default_nettype wire

// ==== hw/hip_swap.sv ====
// Purpose: optional byte reversal of a dword and its lane enables
// Assumes: big selects big-endian view of the dword
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module hip_swap (
  input wire logic big, // reverse bytes when high
  input wire logic [31:0] din, // dword in
  input wire logic [3:0] bein, // lane enables in
  output logic [31:0] dout, // dword out
  output logic [3:0] beout // lane enables out
);
  logic [31:0] rev_d; // bytes reversed
  logic [3:0] rev_be; // lanes reversed

  assign rev_d = {din[7:0], din[15:8], din[23:16], din[31:24]};
  assign rev_be = {bein[0], bein[1], bein[2], bein[3]};
  assign dout = big ? rev_d : din;
  assign beout = big ? rev_be : bein;
endmodule
`default_nettype wire

// ==== hw/hip_port.sv ====
// Purpose: host parallel port, multiplexed address/data, indexed access
// Assumes: host pins asynchronous to mclk; internal memory answers on
//   mem_rdata while a read cycle is open; fifo data sits ready on fifo_rdata
// Notes: strobe and latch timing is resolved by pin synchronisers, so a
//   host cycle must last several mclk periods
`timescale 1ns/1ps
`default_nettype none
module hip_port
  import hip_pkg::*;
(
  input wire logic mclk, // system clock, 50 MHz
  input wire logic nrst, // synchronous reset, low
  input wire logic cfg_rw_enb, // 1: direction/enable signalling
  input wire logic cfg_bus16, // 1: 16-bit data bus
  input wire logic cfg_dual_phase, // 1: two-phase address latching
  input wire logic cfg_ale_qual, // 1: latches need cs active
  input wire logic cfg_pol_ale, // latch enables active level
  input wire logic cfg_pol_cs, // chip select active level
  input wire logic cfg_pol_rd, // read strobe or write-direction level
  input wire logic cfg_pol_wr, // write strobe or access_enable level
  input wire logic pin_cs, // chip select pin
  input wire logic pin_rd_dir, // read strobe or direction pin
  input wire logic pin_wr_en, // write strobe or access_enable pin
  input wire logic addr_latch_low, // low address latch enable
  input wire logic addr_latch_high, // high address latch enable
  input wire logic [15:0] ad_in, // address/data lines, in
  output logic [15:0] ad_out, // address/data lines, out
  output logic [1:0] ad_oe_n, // per-byte drive, low drives
  output logic mem_req, // internal access pulse
  output logic mem_we, // internal access is a write
  output logic [15:0] mem_addr, // internal byte address
  output logic [3:0] mem_be, // internal lane enables
  output logic [31:0] mem_wdata, // internal write data
  input wire logic [31:0] mem_rdata, // internal read data
  output logic fifo_wr, // push pulse, write fifo
  output logic [31:0] fifo_wdata, // push data
  output logic [3:0] fifo_be, // lanes of push or pop
  output logic fifo_rd, // pop pulse, read fifo
  input wire logic [31:0] fifo_rdata // head of read fifo
);
  // synchronised pins
  logic [20:0] raw; // pins into the synchroniser
  logic [20:0] syn; // filtered pin levels
  logic [15:0] ad_s; // filtered data lines
  logic cs_a; // chip select active
  logic rd_a; // read strobe active
  logic wr_a; // write strobe or enable active
  logic dir_wr; // direction line shows write
  logic alo_a; // low latch active
  logic ahi_a; // high latch active
  logic cyc_rd; // read cycle conditions hold
  logic cyc_wr; // write cycle conditions hold
  logic rd_go; // read cycle opens
  logic wr_go; // write cycle opens
  logic rd_end; // read cycle closes
  logic wr_end; // write cycle closes
  logic ale_ok; // latch pulses may be taken
  logic alo_fall; // low latch trailing edge
  logic ahi_fall; // high latch trailing edge
  // address and decode
  logic [4:0] eff_a; // map address seen by decode
  logic mapped; // upper address bits are zero
  hip_tgt_t tgt; // target class
  logic [1:0] pair; // pair number for index/data
  logic big; // byte order of the target
  logic [31:0] rd_native; // target dword, native order
  logic [31:0] rd_dw; // target dword, host order
  logic [15:0] rd_host; // host slice of the dword
  logic [31:0] wr_fill; // host data in all lanes
  logic [3:0] host_be; // lanes in host order
  logic [31:0] wr_dw; // write data, native order
  logic [3:0] nat_be; // lanes, native order
  logic [3:0] cfg_new; // config bits from a write
  logic [15:0] idx_sel; // index of the addressed pair
  logic [15:0] idx_new; // index after a write
  // registers
  hip_state_t state_q, state_d; // cycle state
  logic rdp_q; // previous cyc_rd
  logic wrp_q; // previous cyc_wr
  logic alop_q; // previous low latch level
  logic ahip_q; // previous high latch level
  logic [7:0] alo_q; // latched low address byte
  logic [7:0] ahi_q; // latched high address byte
  logic [15:0] wd_q; // last data seen in a write
  logic [15:0] idx_q [3]; // index pointers
  logic [3:0] cfg_q; // byte-order bits, pairs then fifo
  logic [15:0] ad_out_q; // read data on the lines
  logic [1:0] ad_oe_n_q; // line drive, low drives
  logic mem_req_q, mem_we_q; // internal access
  logic [15:0] mem_addr_q; // internal address
  logic [3:0] mem_be_q; // internal lanes
  logic [31:0] mem_wdata_q; // internal write data
  logic fifo_wr_q, fifo_rd_q; // fifo pulses
  logic [31:0] fifo_wdata_q; // fifo push data
  logic [3:0] fifo_be_q; // fifo lanes

  assign raw = {addr_latch_high, addr_latch_low, pin_cs, pin_rd_dir, pin_wr_en, ad_in};

  hip_sync #(.W(21)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din(raw),
    .dout(syn)
  );

  // pin levels against their programmed active level
  assign ad_s = syn[15:0];
  assign wr_a = syn[16] == cfg_pol_wr;
  assign rd_a = syn[17] == cfg_pol_rd;
  assign dir_wr = rd_a;
  assign cs_a = syn[18] == cfg_pol_cs;
  assign alo_a = syn[19] == cfg_pol_ale;
  assign ahi_a = syn[20] == cfg_pol_ale;

  // cycle framing; cs dropping also ends a cycle, as cs moves only with the strobe
  assign cyc_rd = cfg_rw_enb ? (cs_a & wr_a & ~dir_wr) : (cs_a & rd_a);
  assign cyc_wr = cfg_rw_enb ? (cs_a & wr_a & dir_wr) : (cs_a & wr_a);
  // previous levels reset high so an active-low pin stuck active at reset opens nothing
  assign rd_go = cyc_rd & ~rdp_q;
  assign wr_go = cyc_wr & ~wrp_q;
  assign rd_end = (state_q == ST_READ) & ~cyc_rd;
  assign wr_end = (state_q == ST_WRITE) & ~cyc_wr;

  // address latch edges
  assign ale_ok = ~cfg_ale_qual | cs_a;
  assign alo_fall = alop_q & ~alo_a & ale_ok;
  assign ahi_fall = ahip_q & ~ahi_a & ale_ok & cfg_dual_phase;

  // decode: 16-bit hosts carry no bit 0
  assign eff_a = cfg_bus16 ? {alo_q[4:1], 1'b0} : alo_q[4:0];
  assign mapped = (ahi_q == 8'h00) & (alo_q[7:5] == 3'h0);
  assign tgt = tgt_of(eff_a);
  assign pair = eff_a[4:3];
  assign idx_sel = (pair == 2'h3) ? 16'h0000 : idx_q[pair];
  // fifo and each pair carry their own order bit; config has none
  assign big = (tgt == TGT_FIFO) ? cfg_q[CFG_FIFO_BIT] :
               (tgt == TGT_CFG) ? 1'b0 : cfg_q[pair];

  // read source, config bits mirrored in every byte
  assign rd_native = ~mapped ? 32'h0000_0000 :
                     (tgt == TGT_IDX) ? {16'h0000, idx_sel} :
                     (tgt == TGT_DATA) ? mem_rdata :
                     (tgt == TGT_FIFO) ? fifo_rdata :
                     {4{4'h0, cfg_q}};

  hip_swap u_rd_swap (
    .big(big),
    .din(rd_native),
    .bein(4'h0),
    .dout(rd_dw),
    .beout()
  );

  assign rd_host = lane_pick(rd_dw, cfg_bus16, eff_a[1:0]);

  // write path: place host data in lanes, then undo the host byte order
  assign wr_fill = lane_fill(wd_q, cfg_bus16);
  assign host_be = lane_be(cfg_bus16, eff_a[1:0]);

  hip_swap u_wr_swap (
    .big(big),
    .din(wr_fill),
    .bein(host_be),
    .dout(wr_dw),
    .beout(nat_be)
  );

  // index bits above 15 are reserved and never stored
  assign idx_new = {nat_be[1] ? wr_dw[15:8] : idx_sel[15:8],
                    nat_be[0] ? wr_dw[7:0] : idx_sel[7:0]};

  // any written shadow copy of a bit sets it
  always_comb begin
    cfg_new = 4'h0;
    for (int j = 0; j < 4; j++) begin
      if (host_be[j]) begin
        cfg_new = cfg_new | wr_fill[CFG_SHADOW_STEP*j +: 4];
      end
    end
  end

  // cycle state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rd_go) begin
          state_d = ST_READ;
        end else if (wr_go) begin
          state_d = ST_WRITE;
        end
      end
      ST_READ: begin
        if (~cyc_rd) begin
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (~cyc_wr) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // edge history and state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      rdp_q <= 1'b1;
      wrp_q <= 1'b1;
      alop_q <= 1'b0;
      ahip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rdp_q <= cyc_rd;
      wrp_q <= cyc_wr;
      alop_q <= alo_a;
      ahip_q <= ahi_a;
    end
  end

  // address latches hold until the next latch pulse
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      alo_q <= 8'h00;
      ahi_q <= 8'h00;
    end else if (alo_fall & ~cfg_dual_phase) begin
      alo_q <= ad_s[7:0];
      ahi_q <= ad_s[15:8];
    end else begin
      if (alo_fall) begin
        alo_q <= ad_s[7:0];
      end
      if (ahi_fall) begin
        ahi_q <= ad_s[7:0];
      end
    end
  end

  // write data follows the lines while the write is open
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wd_q <= 16'h0000;
    end else if (cyc_wr) begin
      wd_q <= ad_s;
    end
  end

  // index and config stores, taken when the write closes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      idx_q <= '{IDX_RESET, IDX_RESET, IDX_RESET};
      cfg_q <= CFG_RESET;
    end else if (wr_end & mapped) begin
      if ((tgt == TGT_IDX) & (pair != 2'h3)) begin
        idx_q[pair] <= idx_new;
      end
      if (tgt == TGT_CFG) begin
        cfg_q <= cfg_new;
      end
    end
  end

  // line drive: lower byte in any read, upper only on a 16-bit bus
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ad_out_q <= 16'h0000;
      ad_oe_n_q <= 2'b11;
    end else if (state_d == ST_READ) begin
      ad_out_q <= rd_host;
      ad_oe_n_q <= {~cfg_bus16, 1'b0};
    end else begin
      ad_out_q <= 16'h0000;
      ad_oe_n_q <= 2'b11;
    end
  end

  // internal access through a data window; read issued when the cycle opens
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_be_q <= 4'h0;
      mem_wdata_q <= 32'h0000_0000;
    end else begin
      mem_req_q <= 1'b0;
      if (mapped & (tgt == TGT_DATA) & ((state_q == ST_IDLE & rd_go) | wr_end)) begin
        mem_req_q <= 1'b1;
        mem_we_q <= wr_end;
        mem_addr_q <= idx_sel;
        mem_be_q <= nat_be;
        mem_wdata_q <= wr_dw;
      end
    end
  end

  // fifo port: push at write close, pop after the host has read
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fifo_wr_q <= 1'b0;
      fifo_rd_q <= 1'b0;
      fifo_wdata_q <= 32'h0000_0000;
      fifo_be_q <= 4'h0;
    end else begin
      fifo_wr_q <= wr_end & mapped & (tgt == TGT_FIFO);
      fifo_rd_q <= rd_end & mapped & (tgt == TGT_FIFO);
      if ((wr_end | rd_end) & mapped & (tgt == TGT_FIFO)) begin
        fifo_wdata_q <= wr_dw;
        fifo_be_q <= nat_be;
      end
    end
  end

  assign ad_out = ad_out_q;
  assign ad_oe_n = ad_oe_n_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_be = mem_be_q;
  assign mem_wdata = mem_wdata_q;
  assign fifo_wr = fifo_wr_q;
  assign fifo_rd = fifo_rd_q;
  assign fifo_wdata = fifo_wdata_q;
  assign fifo_be = fifo_be_q;
endmodule
`default_nettype wire

// ==== verif/hip_port_props.sv ====
// Purpose: property checker of the host index port
// Assumes: raw pin levels decoded with the configured polarities
// Notes: pin filtering costs some cycles, so bounds are a few wide
`timescale 1ns/1ps
`default_nettype none
module hip_chk (
  input wire logic mclk, // clock
  input wire logic nrst, // reset, low
  input wire logic cfg_rw_enb, // enable mode
  input wire logic cfg_bus16, // wide bus
  input wire logic cfg_pol_cs, // cs level
  input wire logic cfg_pol_rd, // rd/dir level
  input wire logic cfg_pol_wr, // wr/enable level
  input wire logic pin_cs, // chip select
  input wire logic pin_rd_dir, // rd or dir
  input wire logic pin_wr_en, // wr or enable
  input wire logic [1:0] ad_oe_n, // drive, low
  input wire logic mem_req, // access pulse
  input wire logic mem_we, // write access
  input wire logic [3:0] mem_be, // lanes
  input wire logic fifo_wr, // push
  input wire logic fifo_rd // pop
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // unfiltered cycle decode straight from the pins
  wire logic cs_on = pin_cs == cfg_pol_cs;
  wire logic dir_on = pin_rd_dir == cfg_pol_rd;
  wire logic we_on = pin_wr_en == cfg_pol_wr;
  wire logic rd_raw = cs_on & (cfg_rw_enb ? we_on & !dir_on : dir_on);
  wire logic wr_raw = cs_on & (cfg_rw_enb ? we_on & dir_on : we_on);
  // cycles since a raw strobe was last seen, saturating at 15
  logic [3:0] since_rd_q;
  logic [3:0] since_wr_q;
  wire logic [3:0] since_rd_d = rd_raw ? 4'h0 : since_rd_q + {3'h0, since_rd_q != 4'hf};
  wire logic [3:0] since_wr_d = wr_raw ? 4'h0 : since_wr_q + {3'h0, since_wr_q != 4'hf};
  always_ff @(posedge mclk) begin
    since_rd_q <= nrst ? since_rd_d : 4'hf;
    since_wr_q <= nrst ? since_wr_d : 4'hf;
  end
  a_oe_off_idle: assert property (!rd_raw [*8] |-> ad_oe_n == 2'b11)
    else $error("lines driven while idle");
  a_oe_width: assert property (ad_oe_n != 2'b11 |-> ad_oe_n == {~cfg_bus16, 1'b0})
    else $error("wrong bytes driven");
  a_oe_on_read: assert property ($fell(ad_oe_n[0]) |-> since_rd_q < 4'h6)
    else $error("drive without read strobe");
  a_read_req: assert property (mem_req && !mem_we |-> since_rd_q < 4'h6)
    else $error("memory read outside read");
  a_write_close: assert property ((fifo_wr || (mem_req && mem_we)) |-> since_wr_q inside {[2:8]})
    else $error("write not at cycle end");
  a_req_pulse: assert property (mem_req |=> !mem_req)
    else $error("access pulse too long");
  a_pop_close: assert property (fifo_rd |-> since_rd_q inside {[1:8]})
    else $error("pop not at read end");
  a_pop_once: assert property (fifo_rd |=> !fifo_rd [*4])
    else $error("double pop");
  a_one_target: assert property ($onehot0({mem_req, fifo_wr, fifo_rd}))
    else $error("two targets at once");
  a_lane_shape: assert property (mem_req |-> (cfg_bus16 ? mem_be inside {4'h3, 4'hc} : $onehot(mem_be)))
    else $error("bad lane enables");
  c_read: cover property (mem_req && !mem_we);
  c_push: cover property (fifo_wr);
  c_mem_write: cover property (mem_req && mem_we);
  c_byte_lane: cover property (mem_req && mem_be == 4'h4);
endmodule
bind hip_port hip_chk i_hip_chk (.mclk, .nrst, .cfg_rw_enb, .cfg_bus16, .cfg_pol_cs,
  .cfg_pol_rd, .cfg_pol_wr, .pin_cs, .pin_rd_dir, .pin_wr_en, .ad_oe_n, .mem_req,
  .mem_we, .mem_be, .fifo_wr, .fifo_rd);
`default_nettype wire

// ==== verif/hip_host.sv ====
// Purpose: host microcontroller model on the port pins
// Assumes: tasks are entered just after a clock edge
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module hip_host (
  input wire logic mclk, // clock
  input wire logic cfg_rw_enb, // enable mode
  input wire logic cfg_dual_phase, // two latch phases
  input wire logic cfg_pol_ale, // latch level
  input wire logic cfg_pol_cs, // cs level
  input wire logic cfg_pol_rd, // rd/dir level
  input wire logic cfg_pol_wr, // wr/enable level
  output logic pin_cs, // chip select
  output logic pin_rd_dir, // rd or dir
  output logic pin_wr_en, // wr or enable
  output logic addr_latch_low, // low latch
  output logic addr_latch_high, // high latch
  output logic [15:0] ad_in, // lines seen
  input wire logic [15:0] ad_out, // device data
  input wire logic [1:0] ad_oe_n // device drive, low
);
  logic cs_l = 1'b0; // chip select
  logic rdd_l = 1'b0; // rd strobe, or write direction
  logic wre_l = 1'b0; // wr strobe or enable
  logic alo_l = 1'b0; // low latch
  logic ahi_l = 1'b0; // high latch
  logic [15:0] ad_h = 16'h0000; // host drive
  // logical levels mapped to configured pin levels
  assign pin_cs = ~(cs_l ^ cfg_pol_cs);
  assign pin_rd_dir = ~(rdd_l ^ cfg_pol_rd);
  assign pin_wr_en = ~(wre_l ^ cfg_pol_wr);
  assign addr_latch_low = ~(alo_l ^ cfg_pol_ale);
  assign addr_latch_high = ~(ahi_l ^ cfg_pol_ale);
  // device byte wins where it drives
  assign ad_in = {ad_oe_n[1] ? ad_h[15:8] : ad_out[15:8],
                  ad_oe_n[0] ? ad_h[7:0] : ad_out[7:0]};
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one latch phase, address held past the trailing edge
  task automatic ph(input logic hi, input logic [15:0] v, input logic cs);
    ad_h <= v;
    cs_l <= cs;
    ahi_l <= hi;
    alo_l <= ~hi;
    wt(5);
    ahi_l <= 1'b0;
    alo_l <= 1'b0;
    wt(4);
    ad_h <= ~v;
    cs_l <= 1'b0;
    wt(2);
  endtask
  // address phase, either half first
  task automatic lat(input logic [15:0] a, input logic hf, input logic cs);
    logic h;
    if (!cfg_dual_phase) begin
      ph(1'b0, a, cs);
    end else begin
      for (int i = 0; i < 2; i++) begin
        h = hf ^ i[0];
        ph(h, {8'h00, h ? a[15:8] : a[7:0]}, cs);
      end
    end
  endtask
  // data cycle, optionally after an address phase
  task automatic acc(input logic l, input logic hf, input logic we, input logic [15:0] a,
                     inout logic [15:0] d);
    if (l) begin
      lat(a, hf, 1'b1);
    end
    ad_h <= we ? d : ~ad_h;
    if (cfg_rw_enb) begin
      rdd_l <= we;
      wt(1);
    end
    cs_l <= 1'b1;
    wre_l <= we | cfg_rw_enb;
    rdd_l <= cfg_rw_enb ? we : ~we;
    wt(10);
    if (!we) begin
      d = ad_in;
    end
    cs_l <= 1'b0;
    wre_l <= 1'b0;
    rdd_l <= rdd_l & cfg_rw_enb;
    wt(2);
    rdd_l <= 1'b0;
    ad_h <= ~ad_h;
    wt(8);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_hip_port.sv ====
// Purpose: self-checking bench of the host index port
// Assumes: host model on the pins, bench answers memory and fifo
// Notes: second reset brings random polarities and 8-bit mode
`timescale 1ns/1ps
`default_nettype none
module tb_hip_port;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_rw_enb = 1'b0, cfg_bus16 = 1'b1, cfg_dual_phase = 1'b0, cfg_ale_qual = 1'b0;
  logic cfg_pol_ale = 1'b1, cfg_pol_cs = 1'b1, cfg_pol_rd = 1'b1, cfg_pol_wr = 1'b1;
  logic pin_cs, pin_rd_dir, pin_wr_en, addr_latch_low, addr_latch_high;
  logic [15:0] ad_in, ad_out, mem_addr;
  logic [1:0] ad_oe_n;
  logic mem_req, mem_we, fifo_wr, fifo_rd;
  logic [3:0] mem_be, fifo_be;
  logic [31:0] mem_wdata, fifo_wdata, md;
  logic [31:0] mem_rdata = 32'h0, fifo_rdata = 32'h0;
  logic [15:0] rnd = 16'h4259; // seed 16985
  logic [15:0] d;
  logic [15:0] v [3]; // index value per pair
  logic [39:0] exp_q [$]; // expected internal pulses
  int mismatches = 0, checked = 0;
  initial forever #10 mclk = ~mclk;
  hip_port i_hip_port (.mclk, .nrst, .cfg_rw_enb, .cfg_bus16, .cfg_dual_phase, .cfg_ale_qual,
    .cfg_pol_ale, .cfg_pol_cs, .cfg_pol_rd, .cfg_pol_wr, .pin_cs, .pin_rd_dir, .pin_wr_en,
    .addr_latch_low, .addr_latch_high, .ad_in, .ad_out, .ad_oe_n, .mem_req, .mem_we,
    .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .fifo_wr, .fifo_wdata, .fifo_be, .fifo_rd,
    .fifo_rdata);
  hip_host i_hip_host (.mclk, .cfg_rw_enb, .cfg_dual_phase, .cfg_pol_ale, .cfg_pol_cs,
    .cfg_pol_rd, .cfg_pol_wr, .pin_cs, .pin_rd_dir, .pin_wr_en, .addr_latch_low,
    .addr_latch_high, .ad_in, .ad_out, .ad_oe_n);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // read with fresh memory and fifo words offered
  task automatic rd(input logic l, input logic [15:0] a);
    rnd = lfsr(rnd);
    md = {rnd, lfsr(rnd)};
    mem_rdata <= md;
    fifo_rdata <= ~md;
    wt(1);
    i_hip_host.acc(l, rnd[0], 1'b0, a, d);
  endtask
  // write; odd offsets latch the high half first
  task automatic wr(input logic [15:0] a, input logic [15:0] x);
    d = x;
    i_hip_host.acc(1'b1, a[0], 1'b1, a, d);
  endtask
  task automatic ev(input logic [3:0] k, input logic [15:0] a, input logic [3:0] be,
                    input logic [15:0] x);
    exp_q.push_back({k, a, be, x});
  endtask
  // each internal pulse takes the oldest note; none left means stray
  always @(posedge mclk) begin
    if (nrst && (mem_req || fifo_wr || fifo_rd)) begin
      chk("event", {mem_req, mem_req & mem_we, fifo_wr, fifo_rd, mem_req ? mem_addr : 16'h0,
        mem_req ? mem_be : fifo_be,
        fifo_wr ? fifo_wdata[15:0] : (mem_req & mem_we) ? mem_wdata[15:0] : 16'h0},
        exp_q.size() > 0 ? exp_q.pop_front() : 40'h0);
    end
  end
  initial begin
    wt(2);
    nrst <= 1'b1;
    wt(4);
    rd(1'b1, 16'h0000);
    chk("index0", d, 16'h1234);
    rd(1'b1, 16'h001c);
    chk("config", d, 16'h0000);
    for (int p = 0; p < 3; p++) begin
      rnd = lfsr(rnd);
      v[p] = rnd;
      wr(16'(8 * p), rnd);
    end
    // both halves of every window, each with its own index
    for (int p = 0; p < 3; p++) begin
      for (int h = 0; h < 2; h++) begin
        ev(4'h8, v[p], h ? 4'hc : 4'h3, 16'h0);
        rd(1'b1, 16'(8 * p + 4 + 2 * h));
        chk("data", d, h ? md[31:16] : md[15:0]);
      end
    end
    ev(4'h8, v[2], 4'hc, 16'h0);
    rd(1'b0, 16'h0000);
    chk("reuse", d, md[31:16]);
    ev(4'h2, 16'h0, 4'h3, rnd);
    wr(16'h0018, rnd);
    ev(4'h1, 16'h0, 4'h3, 16'h0);
    rd(1'b1, 16'h0018);
    chk("fifo", d, fifo_rdata[15:0]);
    wr(16'h001c, 16'h0002);
    rd(1'b1, 16'h001c);
    chk("config", d, 16'h0202);
    ev(4'h8, v[1], 4'hc, 16'h0);
    rd(1'b1, 16'h000c);
    chk("swap", d, {md[23:16], md[31:24]});
    ev(4'h8, v[0], 4'h3, 16'h0);
    rd(1'b1, 16'h0004);
    chk("order", d, md[15:0]);
    // data window write: the host word lands in the low lanes of the dword
    ev(4'hc, v[0], 4'h3, rnd);
    wr(16'h0004, rnd);
    wr(16'h0104, 16'h5555);
    rd(1'b1, 16'h0024);
    chk("unmapped", d, 16'h0000);
    // second reset: random polarities, 8-bit, enable mode, qualified latches
    nrst <= 1'b0;
    rnd = lfsr(rnd);
    {cfg_pol_ale, cfg_pol_cs, cfg_pol_rd, cfg_pol_wr} <= rnd[3:0];
    cfg_bus16 <= 1'b0;
    cfg_rw_enb <= 1'b1;
    cfg_dual_phase <= 1'b1;
    cfg_ale_qual <= 1'b1;
    wt(4);
    nrst <= 1'b1;
    wt(4);
    rd(1'b1, 16'h0001);
    chk("byte", d[7:0], 8'h12);
    rnd = lfsr(rnd);
    v[2] = rnd;
    wr(16'h0010, {8'h00, v[2][7:0]});
    wr(16'h0011, {8'h00, v[2][15:8]});
    ev(4'h8, v[2], 4'h4, 16'h0);
    rd(1'b1, 16'h0016);
    chk("byte", d[7:0], md[23:16]);
    i_hip_host.lat(16'h0004, 1'b0, 1'b0);
    ev(4'h8, v[2], 4'h4, 16'h0);
    rd(1'b0, 16'h0000);
    chk("qualified", d[7:0], md[23:16]);
    wt(10);
    chk("queue", exp_q.size(), 40'h0);
    stop_test();
  end
  // hang guard, far beyond the roughly 900 cycles needed
  initial begin
    wt(20000);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
